//--- hw/uoc_pkg.sv
// Constants and types for the OUT endpoint configuration block
// How it works
// - Config bits mean control/interrupt/bulk behaviour only while the isochronous bit is clear.
// - The toggle bit flips after a good data-stage packet whose data PID matches the toggle.
// - With double buffering on, received packets alternate between the X and Y buffers.
// - With double buffering off, packets go only to the X buffer.
// - The endpoint interrupt is raised only while the interrupt-enable bit is set.
// - Too much data in a control write makes the buffer manager set the stall bit.
// - A stored packet sets its buffer's no-ack flag, and OUT data for that buffer is NAKed until software clears it.
package uoc_pkg;
    localparam int unsigned ADDR_W = 2;
    localparam logic [1:0] OFS_CFG = 2'h0;
    localparam logic [1:0] OFS_NAK = 2'h1;
    localparam logic [1:0] OFS_IST = 2'h2;
    localparam logic [1:0] OFS_IMSK = 2'h3;
    localparam int BIT_EN = 7;
    localparam int BIT_ISO = 6;
    localparam int BIT_TOG = 5;
    localparam int BIT_DOUBLE_BUFFER_SELECT = 4;
    localparam int BIT_STALL = 3;
    localparam int BIT_IE = 2;
    localparam int NAK_X = 0;
    localparam int NAK_Y = 1;
    localparam int IST_RX = 0;
    localparam int IST_STALL = 1;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] NAK_RST = 2'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    typedef enum logic [1:0] {RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL} uoc_resp_t;
endpackage

//--- hw/uoc_if.sv
// Signals between the register file and the transaction handler
`timescale 1ns/100ps
interface uoc_if;
    logic en;
    logic iso;
    logic tog;
    logic double_buffer_select;
    logic stall;
    logic [1:0] nak;
    logic flip;
    logic set_nak_x;
    logic set_nak_y;
    logic set_stall;
    modport regs (output en, iso, tog, double_buffer_select, stall, nak,
                  input flip, set_nak_x, set_nak_y, set_stall);
    modport ctl (input en, iso, tog, double_buffer_select, stall, nak,
                 output flip, set_nak_x, set_nak_y, set_stall);
endinterface

//--- hw/uoc_ctl.sv
// Per-transaction handshake and buffer decisions for the OUT endpoint
`timescale 1ns/100ps
module uoc_ctl (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Transaction events from the packet engine
    input wire logic txn_i,
    input wire logic setup_i,
    input wire logic pkt_ok_i,
    input wire logic data_pid_i,
    input wire logic over_i,
    // Answers
    output logic resp_vld_o,
    output uoc_pkg::uoc_resp_t resp_o,
    output logic store_o,
    output logic store_y_o,
    uoc_if.ctl cf
);
    typedef struct packed {
        uoc_pkg::uoc_resp_t resp;
        logic resp_vld;
        logic buf_y;
        logic store;
        logic store_y;
        logic flip;
        logic set_nak_x;
        logic set_nak_y;
        logic set_stall;
    } uoc_ctl_t;

    uoc_ctl_t s_r;
    uoc_ctl_t s_nxt;
    logic cur_nak;

    always_comb begin
        s_nxt = s_r;
        s_nxt.resp_vld = 1'b0;
        s_nxt.store = 1'b0;
        s_nxt.store_y = 1'b0;
        s_nxt.flip = 1'b0;
        s_nxt.set_nak_x = 1'b0;
        s_nxt.set_nak_y = 1'b0;
        s_nxt.set_stall = 1'b0;
        // Pointer may still show Y for one cycle after double buffering is switched off
        cur_nak = (s_r.buf_y && cf.double_buffer_select) ? cf.nak[uoc_pkg::NAK_Y] : cf.nak[uoc_pkg::NAK_X];
        if (!cf.double_buffer_select) begin
            s_nxt.buf_y = 1'b0;
        end
        // Isochronous traffic is handled elsewhere; nothing here answers it
        if (txn_i && cf.en && !cf.iso && pkt_ok_i) begin
            s_nxt.resp_vld = 1'b1;
            if (cf.stall && !setup_i) begin
                s_nxt.resp = uoc_pkg::RESP_STALL;
            end else if (cur_nak && !setup_i) begin
                s_nxt.resp = uoc_pkg::RESP_NAK;
            end else if (!setup_i && data_pid_i != cf.tog) begin
                // Retried packet: acknowledge but drop, host missed our ACK
                s_nxt.resp = uoc_pkg::RESP_ACK;
            end else begin
                s_nxt.resp = uoc_pkg::RESP_ACK;
                s_nxt.store = 1'b1;
                s_nxt.store_y = s_r.buf_y && cf.double_buffer_select;
                s_nxt.set_nak_x = !(s_r.buf_y && cf.double_buffer_select);
                s_nxt.set_nak_y = s_r.buf_y && cf.double_buffer_select;
                s_nxt.flip = !setup_i;
                s_nxt.buf_y = cf.double_buffer_select && !s_r.buf_y;
            end
        end
        if (over_i && cf.en && !cf.iso) begin
            s_nxt.set_stall = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign resp_vld_o = s_r.resp_vld;
    assign resp_o = s_r.resp;
    assign store_o = s_r.store;
    assign store_y_o = s_r.store_y;
    assign cf.flip = s_r.flip;
    assign cf.set_nak_x = s_r.set_nak_x;
    assign cf.set_nak_y = s_r.set_nak_y;
    assign cf.set_stall = s_r.set_stall;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_iso_silent: assert property (txn_i && cf.iso |=> !resp_vld_o)
        else $error("answer given on isochronous endpoint");
    a_single_x_only: assert property (!cf.double_buffer_select && !$past(cf.double_buffer_select) |-> !(store_o && store_y_o))
        else $error("Y buffer used in single mode");
    a_nak_when_full: assert property (txn_i && cf.en && !cf.iso && pkt_ok_i && !setup_i
        && !cf.stall && !cf.double_buffer_select && cf.nak[uoc_pkg::NAK_X] |=> resp_o == uoc_pkg::RESP_NAK)
        else $error("full X buffer not answered with NAK");
    a_flip_on_match: assert property (txn_i && cf.en && !cf.iso && pkt_ok_i && !setup_i
        && !cf.stall && !cf.double_buffer_select && !cf.nak[uoc_pkg::NAK_X] && data_pid_i == cf.tog
        |=> cf.flip && store_o)
        else $error("matching packet did not flip toggle");
    a_double_alt: assert property (store_o && cf.double_buffer_select && $past(cf.double_buffer_select)
        |-> s_r.buf_y == !store_y_o)
        else $error("buffer pointer did not alternate");
endmodule

//--- hw/uoc_top.sv
// OUT endpoint configuration byte with no-ack flags and interrupt logic
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
module uoc_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [uoc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Packet engine events
    input wire logic txn_i,
    input wire logic setup_i,
    input wire logic pkt_ok_i,
    input wire logic data_pid_i,
    input wire logic over_i,
    // Handshake, buffer and interrupt outputs
    output logic resp_vld_o,
    output uoc_pkg::uoc_resp_t resp_o,
    output logic store_o,
    output logic store_y_o,
    output logic irq_o
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [1:0] nak;
        logic [1:0] ist;
        logic [1:0] imsk;
        logic [7:0] rdata;
        logic irq;
    } uoc_regs_t;

    uoc_regs_t s_r;
    uoc_regs_t s_nxt;
    uoc_if cf ();

    uoc_ctl u_ctl (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .txn_i(txn_i),
        .setup_i(setup_i),
        .pkt_ok_i(pkt_ok_i),
        .data_pid_i(data_pid_i),
        .over_i(over_i),
        .resp_vld_o(resp_vld_o),
        .resp_o(resp_o),
        .store_o(store_o),
        .store_y_o(store_y_o),
        .cf(cf.ctl)
    );

    assign cf.en = s_r.cfg[uoc_pkg::BIT_EN];
    assign cf.iso = s_r.cfg[uoc_pkg::BIT_ISO];
    assign cf.tog = s_r.cfg[uoc_pkg::BIT_TOG];
    assign cf.double_buffer_select = s_r.cfg[uoc_pkg::BIT_DOUBLE_BUFFER_SELECT];
    assign cf.stall = s_r.cfg[uoc_pkg::BIT_STALL];
    assign cf.nak = s_r.nak;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (wr_i) begin
            unique case (addr_i)
                uoc_pkg::OFS_CFG: s_nxt.cfg = wdata_i;
                uoc_pkg::OFS_NAK: s_nxt.nak = wdata_i[1:0];
                uoc_pkg::OFS_IST: s_nxt.ist = s_r.ist & ~wdata_i[1:0];
                uoc_pkg::OFS_IMSK: s_nxt.imsk = wdata_i[1:0];
            endcase
        end
        // Hardware updates come after software so a same-cycle set wins
        if (cf.flip) begin
            s_nxt.cfg[uoc_pkg::BIT_TOG] = !s_nxt.cfg[uoc_pkg::BIT_TOG];
        end
        if (cf.set_stall) begin
            s_nxt.cfg[uoc_pkg::BIT_STALL] = 1'b1;
            s_nxt.ist[uoc_pkg::IST_STALL] = 1'b1;
        end
        if (cf.set_nak_x) begin
            s_nxt.nak[uoc_pkg::NAK_X] = 1'b1;
        end
        if (cf.set_nak_y) begin
            s_nxt.nak[uoc_pkg::NAK_Y] = 1'b1;
        end
        if (store_o) begin
            s_nxt.ist[uoc_pkg::IST_RX] = 1'b1;
        end
        s_nxt.irq = s_nxt.cfg[uoc_pkg::BIT_IE] && |(s_nxt.ist & s_nxt.imsk);
        if (rd_i) begin
            unique case (addr_i)
                uoc_pkg::OFS_CFG: s_nxt.rdata = s_r.cfg;
                uoc_pkg::OFS_NAK: s_nxt.rdata = {6'h00, s_r.nak};
                uoc_pkg::OFS_IST: s_nxt.rdata = {6'h00, s_r.ist};
                uoc_pkg::OFS_IMSK: s_nxt.rdata = {6'h00, s_r.imsk};
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r.cfg <= uoc_pkg::CFG_RST;
            s_r.nak <= uoc_pkg::NAK_RST;
            s_r.ist <= uoc_pkg::IRQ_RST;
            s_r.imsk <= uoc_pkg::IRQ_RST;
            s_r.rdata <= 8'h00;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign irq_o = s_r.irq;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_irq_needs_ie: assert property (irq_o |-> s_r.cfg[uoc_pkg::BIT_IE])
        else $error("interrupt without enable");
    a_stall_set: assert property (cf.set_stall |=> s_r.cfg[uoc_pkg::BIT_STALL])
        else $error("overflow did not stall endpoint");
    a_toggle_flip: assert property (cf.flip && !wr_i |=>
        s_r.cfg[uoc_pkg::BIT_TOG] != $past(s_r.cfg[uoc_pkg::BIT_TOG]))
        else $error("toggle did not invert");
    a_nak_sticky: assert property (cf.set_nak_x |=> s_r.nak[uoc_pkg::NAK_X])
        else $error("no-ack flag not set on store");
    a_reserved_rw: assert property (wr_i && addr_i == uoc_pkg::OFS_CFG ##1 rd_i
        && addr_i == uoc_pkg::OFS_CFG && !wr_i |=> rdata_o[1:0] == $past(wdata_i[1:0], 2))
        else $error("reserved bits not stored");
endmodule

//--- verif/uoc_host.sv
// Host model that issues OUT and SETUP transactions to the endpoint
`timescale 1ns/100ps
module uoc_host (
    // Clock
    input wire logic mclk_i,
    // Transaction events
    output logic txn_o,
    output logic setup_o,
    output logic pkt_ok_o,
    output logic data_pid_o,
    output logic over_o
);
    initial begin
        txn_o = 1'b0;
        setup_o = 1'b1;
        pkt_ok_o = 1'b0;
        data_pid_o = 1'b1;
        over_o = 1'b0;
    end

    // Qualifiers flip once txn drops so a stale value never looks valid
    task automatic send(input logic s, input logic k, input logic p);
        @(posedge mclk_i);
        txn_o <= 1'b1;
        setup_o <= s;
        pkt_ok_o <= k;
        data_pid_o <= p;
        @(posedge mclk_i);
        txn_o <= 1'b0;
        setup_o <= ~s;
        pkt_ok_o <= ~k;
        data_pid_o <= ~p;
        #1;
    endtask

    task automatic overrun;
        @(posedge mclk_i);
        over_o <= 1'b1;
        @(posedge mclk_i);
        over_o <= 1'b0;
        #1;
    endtask
endmodule

//--- verif/uoc_top_tb.sv
// Self-checking bench for the OUT endpoint configuration block
`timescale 1ns/100ps
module uoc_top_tb;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic txn_i, setup_i, pkt_ok_i, data_pid_i, over_i;
    logic resp_vld_o, store_o, store_y_o, irq_o;
    uoc_pkg::uoc_resp_t resp_o;
    int fails = 0;
    int tests_run = 0;

    always #5 mclk_i = ~mclk_i;

    uoc_top i_uoc_top (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .txn_i, .setup_i, .pkt_ok_i, .data_pid_i, .over_i, .resp_vld_o, .resp_o,
        .store_o, .store_y_o, .irq_o);
    uoc_host i_uoc_host (.mclk_i, .txn_o(txn_i), .setup_o(setup_i), .pkt_ok_o(pkt_ok_i),
        .data_pid_o(data_pid_i), .over_o(over_i));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_then_rd(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, d);
    endtask

    task automatic irq_is(input logic e);
        @(posedge mclk_i);
        #1 chk({7'h00, irq_o}, {7'h00, e});
    endtask

    task automatic xf(input logic s, k, p, v, st, y, input uoc_pkg::uoc_resp_t r);
        i_uoc_host.send(s, k, p);
        chk({5'h00, resp_vld_o, store_o, store_y_o}, {5'h00, v, st, y});
        if (v) chk({6'h00, resp_o}, {6'h00, r});
    endtask

    task automatic t_reset;
        for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
        irq_is(1'b0);
        $display("done reset values");
    endtask

    task automatic t_toggle;
        wr(uoc_pkg::OFS_IMSK, 8'h03);
        wr(uoc_pkg::OFS_CFG, 8'h84);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        rd(uoc_pkg::OFS_CFG, 8'hA4);
        rd(uoc_pkg::OFS_NAK, 8'h01);
        irq_is(1'b1);
        xf(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, uoc_pkg::RESP_NAK);
        wr(uoc_pkg::OFS_NAK, 8'h00);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, uoc_pkg::RESP_ACK);
        rd(uoc_pkg::OFS_CFG, 8'hA4);
        wr(uoc_pkg::OFS_CFG, 8'h80);
        irq_is(1'b0);
        wr(uoc_pkg::OFS_CFG, 8'h84);
        irq_is(1'b1);
        wr(uoc_pkg::OFS_IST, 8'h01);
        irq_is(1'b0);
        $display("done toggle and no-ack");
    endtask

    task automatic t_bufs;
        wr(uoc_pkg::OFS_CFG, 8'h90);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        xf(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, uoc_pkg::RESP_ACK);
        rd(uoc_pkg::OFS_NAK, 8'h03);
        wr(uoc_pkg::OFS_NAK, 8'h00);
        wr(uoc_pkg::OFS_CFG, 8'h80);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        wr(uoc_pkg::OFS_NAK, 8'h00);
        xf(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        wr(uoc_pkg::OFS_NAK, 8'h00);
        $display("done buffer modes");
    endtask

    task automatic t_stall;
        wr(uoc_pkg::OFS_IST, 8'h03);
        wr(uoc_pkg::OFS_CFG, 8'h80);
        i_uoc_host.overrun();
        rd(uoc_pkg::OFS_CFG, 8'h88);
        rd(uoc_pkg::OFS_IST, 8'h02);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, uoc_pkg::RESP_STALL);
        // SETUP must still get through a stalled control endpoint
        xf(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        wr(uoc_pkg::OFS_NAK, 8'h00);
        wr(uoc_pkg::OFS_CFG, 8'hC0);
        xf(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, uoc_pkg::RESP_NONE);
        wr(uoc_pkg::OFS_CFG, 8'h80);
        xf(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, uoc_pkg::RESP_NONE);
        rd(uoc_pkg::OFS_CFG, 8'h80);
        $display("done stall and type");
    endtask

    task automatic t_resv;
        wr_then_rd(uoc_pkg::OFS_CFG, 8'h82);
        wr(uoc_pkg::OFS_CFG, 8'h83);
        rd(uoc_pkg::OFS_CFG, 8'h83);
        xf(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, uoc_pkg::RESP_ACK);
        rd(uoc_pkg::OFS_CFG, 8'hA3);
        $display("done reserved bits");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_toggle();
        t_bufs();
        t_stall();
        t_resv();
        finish_test();
    end

    // A hang counts as a mismatch
    initial begin
        #200000;
        fails++;
        finish_test();
    end
endmodule
